// ==== hw/rasc_range_alarm.v ====
`timescale 1ns/10ps
`include "rasc_map.vh"
module rasc_range_alarm #(
   parameter [31:0] BTN_MIN_CYC = `RASC_BTN_MIN_S * `RASC_CLK_HZ,
   parameter [31:0] BTN_MAX_CYC = `RASC_BTN_MAX_S * `RASC_CLK_HZ,
   parameter [31:0] DISP_CYC = `RASC_DISP_S * `RASC_CLK_HZ
)(
   input wire clk,
   input wire resetn,
   input wire [23:0] pressure,
   input wire sampleValid,
   input wire [23:0] sensorLimit,
   input wire [23:0] rangeValue,
   input wire lowerRangeWrite,
   input wire upperRangeWrite,
   input wire zeroButtonPin,
   input wire spanButtonPin,
   input wire writeProtectPin,
   input wire alarmHighSwitchPin,
   input wire [5:0] dampIn,
   input wire dampWrite,
   input wire [3:0] displaySelect,
   input wire [19:0] scaledValue,
   input wire [19:0] temperature,
   input wire selfCheckFail,
   input wire alarmDirIn,
   input wire alarmDirWrite,
   input wire [1:0] levelSet,
   input wire [11:0] customLowSat,
   input wire [11:0] customLowAlarm,
   input wire [11:0] customHighSat,
   input wire [11:0] customHighAlarm,
   input wire customWrite,
   input wire burstMode,
   output reg [23:0] lowerRangeValue_q,
   output reg [23:0] upperRangeValue_q,
   output reg [23:0] span_q,
   output reg [5:0] dampTime_q,
   output reg [23:0] primaryProcessValue_q,
   output reg signed [16:0] percentOfRange_q,
   output reg [39:0] displayLine1_q,
   output reg [47:0] displayLine2_q,
   output reg [1:0] displayItem_q,
   output reg alarmHigh_q,
   output reg [1:0] loopMode_q,
   output reg [11:0] loopCurrent_q,
   output reg customReject_q,
   output reg [23:0] burstPv_q,
   output reg signed [16:0] burstPercent_q,
   output reg [19:0] burstTemp_q,
   output reg burstStatus_q
);
   localparam [2:0] DIV_IDLE = 3'b001;
   localparam [2:0] DIV_RUN = 3'b010;
   localparam [2:0] DIV_DONE = 3'b100;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function inWin;
      input [11:0] v;
      input [11:0] lo;
      input [11:0] hi;
      begin
         inWin = (v >= lo) && (v <= hi);
      end
   endfunction

   function heldOk;
      input [31:0] cnt;
      input [31:0] mn;
      input [31:0] mx;
      begin
         heldOk = (cnt >= mn) && (cnt <= mx);
      end
   endfunction

   function [7:0] hexChar;
      input [3:0] n;
      begin
         hexChar = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
      end
   endfunction

   function [3:0] dampShift;
      input [5:0] d;
      begin
         dampShift = (d >= 6'd32) ? 4'd6 : (d >= 6'd16) ? 4'd5 : (d >= 6'd8) ? 4'd4
            : (d >= 6'd4) ? 4'd3 : (d >= 6'd2) ? 4'd2 : 4'd1;
      end
   endfunction

   // Nearest selected item after cur, last hit wins
   function [1:0] nextItem;
      input [1:0] cur;
      input [3:0] mask;
      integer i;
      begin
         nextItem = cur;
         for (i = 4; i > 0; i = i - 1)
            if (mask[cur + i[1:0]])
               nextItem = cur + i[1:0];
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [3:0] pinMeta_q;
   reg [3:0] pinSync_q;
   wire zeroBtn = pinSync_q[0];
   wire spanBtn = pinSync_q[1];
   wire writeProtect = pinSync_q[2];
   wire alarmSwitch = pinSync_q[3];
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pinMeta_q <= 4'h0;
         pinSync_q <= 4'h0;
      end
      else
      begin
         pinMeta_q <= {alarmHighSwitchPin, writeProtectPin, spanButtonPin, zeroButtonPin};
         pinSync_q <= pinMeta_q;
      end
   end

   // ----------------------------------------
   // Button hold timers
   // ----------------------------------------
   reg [31:0] zeroCnt_q;
   reg [31:0] spanCnt_q;
   reg zeroPrev_q;
   reg spanPrev_q;
   wire zeroCapture = zeroPrev_q && !zeroBtn && heldOk(zeroCnt_q, BTN_MIN_CYC, BTN_MAX_CYC)
      && !writeProtect; // RULE4 RULE23
   wire spanCapture = spanPrev_q && !spanBtn && heldOk(spanCnt_q, BTN_MIN_CYC, BTN_MAX_CYC)
      && !writeProtect; // RULE5 RULE23
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         zeroCnt_q <= 32'h0;
         spanCnt_q <= 32'h0;
         zeroPrev_q <= 1'b0;
         spanPrev_q <= 1'b0;
      end
      else
      begin
         zeroPrev_q <= zeroBtn;
         spanPrev_q <= spanBtn;
         if (!zeroBtn)
            zeroCnt_q <= 32'h0;
         else if (zeroCnt_q <= BTN_MAX_CYC)
            zeroCnt_q <= zeroCnt_q + 32'h1;
         if (!spanBtn)
            spanCnt_q <= 32'h0;
         else if (spanCnt_q <= BTN_MAX_CYC)
            spanCnt_q <= spanCnt_q + 32'h1;
      end
   end

   // ----------------------------------------
   // Range points
   // ----------------------------------------
   reg initLoad_q;
   wire lowerReq = lowerRangeWrite || zeroCapture;
   wire upperReq = upperRangeWrite || spanCapture;
   wire [23:0] lowerNew = zeroCapture ? pressure : rangeValue;
   wire [23:0] upperNew = spanCapture ? pressure : rangeValue;
   wire [24:0] shiftedUpper = {1'b0, lowerNew} + {1'b0, span_q};
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         initLoad_q <= 1'b1;
         lowerRangeValue_q <= 24'h0;
         upperRangeValue_q <= 24'h0;
         span_q <= 24'h0;
      end
      else if (initLoad_q)
      begin
         initLoad_q <= 1'b0;
         upperRangeValue_q <= sensorLimit;
         span_q <= sensorLimit;
      end
      else if (lowerReq && lowerNew < sensorLimit)
      begin
         lowerRangeValue_q <= lowerNew;
         if (shiftedUpper > {1'b0, sensorLimit})
         begin
            upperRangeValue_q <= sensorLimit; // RULE3
            span_q <= sensorLimit - lowerNew; // RULE3
         end
         else
            upperRangeValue_q <= shiftedUpper[23:0]; // RULE1
      end
      else if (upperReq && upperNew > lowerRangeValue_q)
      begin
         upperRangeValue_q <= upperNew;
         span_q <= upperNew - lowerRangeValue_q; // RULE2
      end
   end

   // ----------------------------------------
   // Damping filter
   // ----------------------------------------
   wire signed [24:0] pvDiff = $signed({1'b0, pressure}) - $signed({1'b0, primaryProcessValue_q});
   wire signed [24:0] pvStep = pvDiff >>> dampShift(dampTime_q);
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dampTime_q <= 6'h0;
         primaryProcessValue_q <= 24'h0;
      end
      else
      begin
         if (dampWrite && dampIn <= `RASC_DAMP_MAX_S)
            dampTime_q <= dampIn; // RULE6
         if (sampleValid)
         begin
            if (dampTime_q == 6'h0)
               primaryProcessValue_q <= pressure;
            else
               primaryProcessValue_q <= primaryProcessValue_q + pvStep[23:0]; // RULE6
         end
      end
   end

   // ----------------------------------------
   // Percent of range, serial divider
   // ----------------------------------------
   reg [2:0] divState_q;
   reg [37:0] divNum_q;
   reg [37:0] divQuot_q;
   reg [24:0] divRem_q;
   reg [5:0] divCnt_q;
   reg divNeg_q;
   reg pvFresh_q;
   wire signed [24:0] pvOffset = $signed({1'b0, primaryProcessValue_q})
      - $signed({1'b0, lowerRangeValue_q});
   wire [24:0] pvAbs = pvOffset[24] ? (25'h0 - pvOffset) : pvOffset;
   wire [24:0] remShift = {divRem_q[23:0], divNum_q[37]};
   wire remGe = remShift >= {1'b0, span_q};
   wire [15:0] quotSat = (divQuot_q[37:15] != 23'h0) ? `RASC_PCT_SAT : {1'b0, divQuot_q[14:0]};
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         divState_q <= DIV_IDLE;
         divNum_q <= 38'h0;
         divQuot_q <= 38'h0;
         divRem_q <= 25'h0;
         divCnt_q <= 6'h0;
         divNeg_q <= 1'b0;
         pvFresh_q <= 1'b0;
         percentOfRange_q <= 17'h0;
      end
      else
      begin
         if (sampleValid)
            pvFresh_q <= 1'b1;
         case (divState_q)
            DIV_IDLE:
            begin
               if (pvFresh_q)
               begin
                  pvFresh_q <= sampleValid;
                  divNum_q <= pvAbs[23:0] * `RASC_PCT_FULL; // RULE22
                  divNeg_q <= pvOffset[24];
                  divQuot_q <= 38'h0;
                  divRem_q <= 25'h0;
                  divCnt_q <= `RASC_DIV_STEPS;
                  divState_q <= DIV_RUN;
               end
            end
            DIV_RUN:
            begin
               divNum_q <= {divNum_q[36:0], 1'b0};
               divRem_q <= remGe ? (remShift - {1'b0, span_q}) : remShift;
               divQuot_q <= {divQuot_q[36:0], remGe};
               divCnt_q <= divCnt_q - 6'h1;
               if (divCnt_q == 6'h1)
                  divState_q <= DIV_DONE;
            end
            DIV_DONE:
            begin
               percentOfRange_q <= divNeg_q ? -$signed({1'b0, quotSat}) : $signed({1'b0, quotSat});
               divState_q <= DIV_IDLE;
            end
            default:
               divState_q <= DIV_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Alarm and saturation levels
   // ----------------------------------------
   reg [11:0] cusLs_q;
   reg [11:0] cusLa_q;
   reg [11:0] cusHs_q;
   reg [11:0] cusHa_q;
   reg switchPrev_q;
   wire customOk = inWin(customLowSat, `RASC_CLS_MIN, `RASC_CLS_MAX) // RULE15
      && inWin(customLowAlarm, `RASC_CLA_MIN, `RASC_CLA_MAX) // RULE15
      && inWin(customHighSat, `RASC_CHS_MIN, `RASC_CHS_MAX) // RULE15 RULE17
      && inWin(customHighAlarm, `RASC_CHA_MIN, `RASC_CHA_MAX) // RULE15
      && (customLowAlarm < customLowSat) && (customHighAlarm > customHighSat) // RULE16
      && (customLowSat - customLowAlarm >= `RASC_MIN_SEP) // RULE18
      && (customHighAlarm - customHighSat >= `RASC_MIN_SEP); // RULE18
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cusLs_q <= `RASC_STD_LS;
         cusLa_q <= `RASC_STD_LA;
         cusHs_q <= `RASC_STD_HS;
         cusHa_q <= `RASC_STD_HA;
         customReject_q <= 1'b0;
         switchPrev_q <= 1'b0;
         alarmHigh_q <= 1'b0;
      end
      else
      begin
         customReject_q <= customWrite && !customOk;
         if (customWrite && customOk)
         begin
            cusLs_q <= customLowSat; // RULE24
            cusLa_q <= customLowAlarm;
            cusHs_q <= customHighSat;
            cusHa_q <= customHighAlarm;
         end
         switchPrev_q <= alarmSwitch;
         if (alarmDirWrite)
            alarmHigh_q <= alarmDirIn; // RULE11
         else if (alarmSwitch != switchPrev_q)
            alarmHigh_q <= alarmSwitch; // RULE11
      end
   end

   wire isNamur = levelSet == `RASC_SET_NAMUR; // RULE12 RULE14
   wire isCustom = levelSet == `RASC_SET_CUSTOM; // RULE12
   wire [11:0] lvlLs = isNamur ? `RASC_NAM_LS : isCustom ? cusLs_q : `RASC_STD_LS; // RULE13
   wire [11:0] lvlLa = isNamur ? `RASC_NAM_LA : isCustom ? cusLa_q : `RASC_STD_LA;
   wire [11:0] lvlHs = isNamur ? `RASC_NAM_HS : isCustom ? cusHs_q : `RASC_STD_HS;
   wire [11:0] lvlHa = isNamur ? `RASC_NAM_HA : isCustom ? cusHa_q : `RASC_STD_HA;

   // ----------------------------------------
   // Loop output decision and burst report
   // ----------------------------------------
   wire belowRange = primaryProcessValue_q < lowerRangeValue_q;
   wire aboveRange = primaryProcessValue_q > upperRangeValue_q;
   wire [13:0] pctClamp = percentOfRange_q[16] ? 14'h0 :
      (percentOfRange_q[15:0] > {2'h0, `RASC_PCT_FULL}) ? `RASC_PCT_FULL : percentOfRange_q[13:0];
   wire [29:0] curProd = pctClamp * `RASC_CUR_RECIP;
   wire [11:0] curLinear = `RASC_CUR_4MA + curProd[`RASC_CUR_SHIFT+11:`RASC_CUR_SHIFT];
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         loopMode_q <= `RASC_MODE_NORMAL;
         loopCurrent_q <= `RASC_CUR_4MA;
         burstPv_q <= 24'h0;
         burstPercent_q <= 17'h0;
         burstTemp_q <= 20'h0;
         burstStatus_q <= 1'b0;
      end
      else
      begin
         if (selfCheckFail)
         begin
            loopMode_q <= `RASC_MODE_ALARM;
            loopCurrent_q <= alarmHigh_q ? lvlHa : lvlLa; // RULE9 RULE11 RULE20
         end
         else if (belowRange || aboveRange)
         begin
            loopMode_q <= `RASC_MODE_SAT;
            loopCurrent_q <= aboveRange ? lvlHs : lvlLs; // RULE10 RULE21
         end
         else
         begin
            loopMode_q <= `RASC_MODE_NORMAL;
            loopCurrent_q <= curLinear;
         end
         if (burstMode)
         begin
            burstPv_q <= primaryProcessValue_q; // RULE22
            burstPercent_q <= percentOfRange_q; // RULE20
            burstTemp_q <= temperature;
            burstStatus_q <= selfCheckFail; // RULE20 RULE21
         end
      end
   end

   // ----------------------------------------
   // Display rotation and text
   // ----------------------------------------
   reg [31:0] dispCnt_q;
   wire [3:0] dispMask = (displaySelect == 4'h0) ? `RASC_ITEM_DEFAULT : displaySelect; // RULE8
   wire [19:0] dispValue = (displayItem_q == 2'd1) ? {{3{percentOfRange_q[16]}}, percentOfRange_q}
      : (displayItem_q == 2'd2) ? scaledValue : (displayItem_q == 2'd3) ? temperature
      : primaryProcessValue_q[19:0];
   wire [47:0] dispUnit = (displayItem_q == 2'd1) ? `RASC_TXT_PCT
      : (displayItem_q == 2'd2) ? `RASC_TXT_SCALED : (displayItem_q == 2'd3) ? `RASC_TXT_TEMP
      : `RASC_TXT_PRESS;

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dispCnt_q <= 32'h0;
         displayItem_q <= 2'd0;
         displayLine1_q <= 40'h0;
         displayLine2_q <= 48'h0;
      end
      else
      begin
         if (dispCnt_q >= DISP_CYC - 32'h1)
         begin
            dispCnt_q <= 32'h0;
            displayItem_q <= nextItem(displayItem_q, dispMask); // RULE8
         end
         else
         begin
            dispCnt_q <= dispCnt_q + 32'h1;
            if (!dispMask[displayItem_q])
               displayItem_q <= nextItem(displayItem_q, dispMask);
         end
         if (selfCheckFail)
         begin
            displayLine1_q <= `RASC_TXT_FAIL; // RULE7
            displayLine2_q <= `RASC_TXT_ERROR;
         end
         else
         begin
            displayLine1_q <= {hexChar(dispValue[19:16]), hexChar(dispValue[15:12]),
               hexChar(dispValue[11:8]), hexChar(dispValue[7:4]), hexChar(dispValue[3:0])}; // RULE7
            displayLine2_q <= dispUnit; // RULE7
         end
      end
   end
endmodule

// ==== hw/rasc_map.vh ====
// Function
// RULE1: New lower range value shifts upper value equally; span is unchanged.
// RULE2: New upper range value keeps lower value; span becomes their difference.
// RULE3: Shifted upper value past sensor limit is clamped there; span shrinks.
// RULE4: Zero button held two to ten seconds captures pressure as lower value.
// RULE5: Span button held two to ten seconds captures pressure as upper value.
// RULE6: Output readings are smoothed; smoothing time 0 to 60 s, readable back.
// RULE7: Display shows five-character value line, six-character unit line, or messages.
// RULE8: Display rotates up to four selected items; default shows pressure only.
// RULE9: Any detected self-check failure forces loop output to alarm current.
// RULE10: Pressure outside range points holds loop output at low or high saturation.
// RULE11: Alarm direction follows hardware switch, also writable over the link.
// RULE12: Three level sets are selectable: standard, NAMUR and custom.
// RULE13: Standard set: 3.9 and 3.75 low, 20.8 and 21.75 high mA.
// RULE14: NAMUR set: 3.8 and 3.6 low, 20.5 and 22.5 high mA.
// RULE15: Custom levels accepted only inside their documented current windows.
// RULE16: Custom valid only with low alarm below and high alarm above saturation.
// RULE17: Custom high saturation above 21.5 mA is rejected.
// RULE18: Alarm and neighbouring saturation levels differ by at least 0.1 mA.
// RULE19: Host reports an error when a custom setting breaks a constraint.
// RULE20: Burst alarm: output to alarm, value and temperature sent with status set.
// RULE21: Burst saturation: output to saturation, value and temperature sent normally.
// RULE22: Reported pressure and percent keep tracking outside range points.
// RULE23: With write protect on, zero and span button attempts are ignored.
// RULE24: Rejected custom configuration leaves previous levels fully in force.
`ifndef RASC_MAP_VH
`define RASC_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define RASC_CLK_HZ 32'd250000000
`define RASC_BTN_MIN_S 32'd2
`define RASC_BTN_MAX_S 32'd10
`define RASC_DISP_S 32'd2
`define RASC_DAMP_MAX_S 6'd60
// ----------------------------------------
// Currents in 10 uA steps
// ----------------------------------------
`define RASC_STD_LS 12'h186
`define RASC_STD_LA 12'h177
`define RASC_STD_HS 12'h820
`define RASC_STD_HA 12'h87f
`define RASC_NAM_LS 12'h17c
`define RASC_NAM_LA 12'h168
`define RASC_NAM_HS 12'h802
`define RASC_NAM_HA 12'h8ca
`define RASC_CLS_MIN 12'h172
`define RASC_CLS_MAX 12'h186
`define RASC_CLA_MIN 12'h168
`define RASC_CLA_MAX 12'h17c
`define RASC_CHS_MIN 12'h7da
`define RASC_CHS_MAX 12'h866
`define RASC_CHA_MIN 12'h7e4
`define RASC_CHA_MAX 12'h8fc
`define RASC_MIN_SEP 12'h00a
`define RASC_CUR_4MA 12'h190
`define RASC_PCT_FULL 14'h2710
`define RASC_CUR_RECIP 16'ha3d7
`define RASC_CUR_SHIFT 20
// ----------------------------------------
// Codes
// ----------------------------------------
`define RASC_SET_STD 2'h0
`define RASC_SET_NAMUR 2'h1
`define RASC_SET_CUSTOM 2'h2
`define RASC_MODE_NORMAL 2'h0
`define RASC_MODE_SAT 2'h1
`define RASC_MODE_ALARM 2'h2
`define RASC_ITEM_DEFAULT 4'h1
`define RASC_TXT_FAIL 40'h4641494c20
`define RASC_TXT_ERROR 48'h4552524f5220
`define RASC_TXT_PRESS 48'h505245535320
`define RASC_TXT_PCT 48'h504354202020
`define RASC_TXT_SCALED 48'h5343414c4544
`define RASC_TXT_TEMP 48'h54454d502020
`define RASC_DIV_STEPS 6'd38
`define RASC_PCT_SAT 16'h7fff
`endif

// ==== test/rasc_range_alarm_monitor.sv ====
`timescale 1ns/10ps
module rasc_range_alarm_monitor (
   input wire clk,
   input wire resetn,
   input wire [23:0] sensorLimit,
   input wire [23:0] rangeValue,
   input wire lowerRangeWrite,
   input wire upperRangeWrite,
   input wire [5:0] dampIn,
   input wire dampWrite,
   input wire selfCheckFail,
   input wire alarmDirIn,
   input wire alarmDirWrite,
   input wire [11:0] customHighSat,
   input wire customWrite,
   input wire burstMode,
   input wire [23:0] lowerRangeValue_q,
   input wire [23:0] upperRangeValue_q,
   input wire [23:0] span_q,
   input wire [5:0] dampTime_q,
   input wire alarmHigh_q,
   input wire [1:0] loopMode_q,
   input wire customReject_q,
   input wire burstStatus_q
);
// ----------------------------------------
// Helpers
// ----------------------------------------
reg armed_q;
wire loOk = armed_q && lowerRangeWrite && rangeValue < sensorLimit;
wire over = {1'b0, rangeValue} + {1'b0, span_q} > {1'b0, sensorLimit};
always @(posedge clk or negedge resetn)
   if (!resetn)
      armed_q <= 1'b0;
   else
      armed_q <= 1'b1;
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
// ----------------------------------------
// Properties
// ----------------------------------------
lo_set_a: assert property (loOk |=> lowerRangeValue_q == $past(rangeValue))
   else $error("lower not taken");
span_keep_a: assert property (loOk && !over |=> span_q == $past(span_q))
   else $error("span moved");
clamp_a: assert property (loOk && over |=> upperRangeValue_q == $past(sensorLimit)
   && span_q == $past(sensorLimit) - $past(rangeValue)) else $error("upper not clamped");
up_span_a: assert property (armed_q && upperRangeWrite && !lowerRangeWrite
   && rangeValue > lowerRangeValue_q |=> span_q == $past(rangeValue) - lowerRangeValue_q)
   else $error("span not recomputed");
damp_ok_a: assert property (dampWrite && dampIn <= 6'd60 |=> dampTime_q == $past(dampIn))
   else $error("damping not taken");
damp_bad_a: assert property (dampWrite && dampIn > 6'd60 |=> $stable(dampTime_q))
   else $error("bad damping taken");
fail_alarm_a: assert property (selfCheckFail |=> loopMode_q == 2'h2)
   else $error("no alarm on failure");
dir_write_a: assert property (alarmDirWrite |=> alarmHigh_q == $past(alarmDirIn))
   else $error("direction not written");
hs_reject_a: assert property (customWrite && customHighSat > 12'h866 |=> customReject_q)
   else $error("high sat accepted");
rej_pulse_a: assert property (customReject_q |-> $past(customWrite))
   else $error("reject without write");
burst_stat_a: assert property (burstMode && selfCheckFail |=> burstStatus_q)
   else $error("burst status not set");
endmodule
bind rasc_range_alarm rasc_range_alarm_monitor u_mon (.clk, .resetn, .sensorLimit,
   .rangeValue, .lowerRangeWrite, .upperRangeWrite, .dampIn, .dampWrite, .selfCheckFail,
   .alarmDirIn, .alarmDirWrite, .customHighSat, .customWrite, .burstMode, .lowerRangeValue_q,
   .upperRangeValue_q, .span_q, .dampTime_q, .alarmHigh_q, .loopMode_q, .customReject_q,
   .burstStatus_q);

// ==== test/rasc_host_model.sv ====
`timescale 1ns/10ps
module rasc_host_model (
   input wire clk,
   input wire resetn,
   input wire customReject_q,
   output reg [7:0] errCount
);
// Each refused custom setting raises one operator error
always @(posedge clk or negedge resetn)
   if (!resetn)
      errCount <= 8'h0;
   else if (customReject_q)
      errCount <= errCount + 8'h1;
endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
module tb;
localparam [23:0] LIM = 24'h100000;
reg clk = 1'b0, resetn = 1'b0, sampleValid = 1'b0, lowerRangeWrite = 1'b0;
reg upperRangeWrite = 1'b0, zeroButtonPin = 1'b0, spanButtonPin = 1'b0, writeProtectPin = 1'b0;
reg alarmHighSwitchPin = 1'b0, dampWrite = 1'b0, selfCheckFail = 1'b0, alarmDirIn = 1'b0;
reg alarmDirWrite = 1'b0, customWrite = 1'b0, burstMode = 1'b0, rej;
reg [23:0] pressure = 24'h0, rangeValue = 24'h0, eLo, eUp, eSp;
reg [5:0] dampIn = 6'h0;
reg [1:0] levelSet = 2'h0, eMode;
reg [19:0] temperature = 20'h0;
reg [11:0] customLowSat = 12'h0, customLowAlarm = 12'h0, customHighSat = 12'h0;
reg [11:0] customHighAlarm = 12'h0, eCur;
reg [31:0] seed = 32'd50200;
integer mismatches = 0, n_tests = 0, i, j;
wire [23:0] lowerRangeValue_q, upperRangeValue_q, span_q, primaryProcessValue_q, burstPv_q;
wire [5:0] dampTime_q;
wire [1:0] loopMode_q;
wire [11:0] loopCurrent_q;
wire [19:0] burstTemp_q;
wire [47:0] displayLine2_q;
wire [7:0] errCount;
wire alarmHigh_q, customReject_q, burstStatus_q;
logic [11:0] almTab [0:3] = '{12'h177, 12'h87f, 12'h168, 12'h8ca};
logic [47:0] badTab [0:3] = '{48'h17c1728678fc, 48'h17c17c80c820, 48'h17c17580c820,
   48'h18717280c820};
always #2 clk = ~clk;
rasc_range_alarm #(.BTN_MIN_CYC(32'd20), .BTN_MAX_CYC(32'd100), .DISP_CYC(32'd16)) dut (
   .clk, .resetn, .pressure, .sampleValid, .sensorLimit(LIM), .rangeValue, .lowerRangeWrite,
   .upperRangeWrite, .zeroButtonPin, .spanButtonPin, .writeProtectPin, .alarmHighSwitchPin,
   .dampIn, .dampWrite, .displaySelect(4'h0), .scaledValue(20'h0), .temperature,
   .selfCheckFail, .alarmDirIn, .alarmDirWrite, .levelSet, .customLowSat, .customLowAlarm,
   .customHighSat, .customHighAlarm, .customWrite, .burstMode, .lowerRangeValue_q,
   .upperRangeValue_q, .span_q, .dampTime_q, .primaryProcessValue_q, .percentOfRange_q(),
   .displayLine1_q(), .displayLine2_q, .displayItem_q(), .alarmHigh_q, .loopMode_q,
   .loopCurrent_q, .customReject_q, .burstPv_q, .burstPercent_q(), .burstTemp_q,
   .burstStatus_q);
rasc_host_model host (.clk, .resetn, .customReject_q, .errCount);
// ----------------------------------------
// Helpers
// ----------------------------------------
function [31:0] xs(input [31:0] s);
   reg [31:0] t;
   begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   end
endfunction
task chk(input [47:0] seen, input [47:0] exp);
   begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   end
endtask
task close_out;
   begin
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
endtask
task mdl(input lower, input [23:0] val);
   begin
      if (lower && val < LIM)
      begin
         eLo = val;
         eUp = ({1'b0, val} + eSp > LIM) ? LIM : val + eSp;
         eSp = eUp - val;
      end
      else if (!lower && val > eLo)
      begin
         eUp = val;
         eSp = val - eLo;
      end
   end
endtask
task rchk;
   begin
      @(negedge clk);
      chk(lowerRangeValue_q, eLo);
      chk(upperRangeValue_q, eUp);
      chk(span_q, eSp);
   end
endtask
task wr(input lower, input [23:0] val);
   begin
      @(posedge clk);
      rangeValue <= val;
      lowerRangeWrite <= lower;
      upperRangeWrite <= !lower;
      @(posedge clk);
      lowerRangeWrite <= 1'b0;
      upperRangeWrite <= 1'b0;
      mdl(lower, val);
      rchk;
   end
endtask
task btn(input span, input prot, input integer n);
   begin
      @(posedge clk);
      writeProtectPin <= prot;
      repeat (3) @(posedge clk);
      spanButtonPin <= span;
      zeroButtonPin <= !span;
      repeat (n) @(posedge clk);
      spanButtonPin <= 1'b0;
      zeroButtonPin <= 1'b0;
      repeat (8) @(posedge clk);
      if (!prot && n > 24 && n < 96)
         mdl(!span, pressure);
      rchk;
   end
endtask
task cw(input [47:0] lv);
   begin
      @(posedge clk);
      {customLowSat, customLowAlarm, customHighSat, customHighAlarm} <= lv;
      customWrite <= 1'b1;
      @(posedge clk);
      customWrite <= 1'b0;
      rej = 1'b0;
      repeat (3)
      begin
         @(negedge clk);
         rej = rej | customReject_q;
      end
   end
endtask
// ----------------------------------------
// Sequence
// ----------------------------------------
initial
begin
   #40000;
   mismatches = mismatches + 1;
   close_out;
end
initial
begin
   repeat (3) @(posedge clk);
   chk(loopCurrent_q, 12'h190);
   resetn <= 1'b1;
   eLo = 24'h0;
   eUp = LIM;
   eSp = LIM;
   repeat (2) @(posedge clk);
   rchk;
   for (i = 0; i < 40; i = i + 1)
   begin
      seed = xs(seed);
      wr(seed[24], {3'h0, seed[20:0]});
   end
   wr(1'b1, LIM);
   wr(1'b0, eLo);
   pressure <= 24'h40000;
   btn(1'b0, 1'b0, 40);
   btn(1'b0, 1'b1, 40);
   pressure <= 24'hc0000;
   btn(1'b1, 1'b0, 8);
   btn(1'b1, 1'b0, 150);
   btn(1'b1, 1'b0, 40);
   for (j = 0; j < 3; j = j + 1)
   begin
      @(posedge clk);
      dampIn <= (j == 1) ? 6'd61 : (j == 0) ? 6'd60 : 6'd0;
      dampWrite <= 1'b1;
      @(posedge clk);
      dampWrite <= 1'b0;
      @(negedge clk);
      chk(dampTime_q, (j == 2) ? 6'd0 : 6'd60);
   end
   wr(1'b1, 24'h10000);
   wr(1'b0, 24'h80000);
   for (i = 0; i < 16; i = i + 1)
   begin
      @(posedge clk);
      burstMode <= 1'b1;
      seed = xs(seed);
      pressure <= {4'h0, seed[19:0]};
      temperature <= seed[31:12];
      levelSet <= {1'b0, seed[21]};
      sampleValid <= 1'b1;
      @(posedge clk);
      sampleValid <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      eMode = (pressure < 24'h10000 || pressure > 24'h80000) ? 2'h1 : 2'h0;
      eCur = (pressure < 24'h10000) ? (seed[21] ? 12'h17c : 12'h186)
         : (seed[21] ? 12'h802 : 12'h820);
      chk(primaryProcessValue_q, pressure);
      chk(loopMode_q, eMode);
      if (eMode == 2'h1)
         chk(loopCurrent_q, eCur);
      chk({burstStatus_q, burstTemp_q, burstPv_q}, {1'b0, temperature, pressure});
   end
   alarmHighSwitchPin <= 1'b1;
   repeat (6) @(posedge clk);
   chk(alarmHigh_q, 1'b1);
   selfCheckFail <= 1'b1;
   for (j = 0; j < 4; j = j + 1)
   begin
      @(posedge clk);
      levelSet <= j[1];
      alarmDirIn <= j[0];
      alarmDirWrite <= 1'b1;
      @(posedge clk);
      alarmDirWrite <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({alarmHigh_q, loopMode_q, burstStatus_q}, {j[0], 2'h2, 1'b1});
      chk(loopCurrent_q, almTab[j]);
      chk(displayLine2_q, 48'h4552524f5220);
   end
   levelSet <= 2'h2;
   cw(48'h17c17280c820);
   chk(rej, 1'b0);
   repeat (3) @(posedge clk);
   chk(loopCurrent_q, 12'h820);
   for (j = 0; j < 4; j = j + 1)
   begin
      cw(badTab[j]);
      chk(rej, 1'b1);
      chk(loopCurrent_q, 12'h820);
   end
   chk(errCount, 8'd4);
   close_out;
end
endmodule
